// >>> common/cmpl_defines.svh
/*
  Constants for the comparator and ladder control block: register byte
  offsets, reset values, bank bit position and bus encodings.
  Assumes inclusion by its bare name from design and bench files.
*/
`ifndef CMPL_DEFINES_SVH
`define CMPL_DEFINES_SVH

`define CMPL_OFS_CMP1       8'h00
`define CMPL_OFS_CMP2       8'h04
`define CMPL_OFS_RESULT     8'h08
`define CMPL_OFS_SHARED     8'h0c
`define CMPL_OFS_WDOG       8'h10
`define CMPL_OFS_FLAGS      8'h14
`define CMPL_OFS_IEN        8'h18

`define CMPL_RST_CMP        8'h00
`define CMPL_RST_LADDER     8'h00
`define CMPL_RST_PERIOD     8'hff
`define CMPL_RST_WDOG       8'h00
`define CMPL_RST_FLAGS      2'h0

`define CMPL_BANK_BIT       4
`define CMPL_NUM_CMP        2

`define CMPL_HTRANS_NONSEQ  2'h2
`define CMPL_HRESP_OKAY     1'h0
`define CMPL_ZERO_WORD      32'h0000_0000

`endif

// >>> common/cmpl_pkg.sv
/*
  Types for the comparator and ladder control block.
  Assumes nothing of its surroundings; no constants live here.
*/
package cmpl_pkg;

  typedef enum logic [1:0] {
    CMPL_EDGE_NONE,
    CMPL_EDGE_RISE,
    CMPL_EDGE_FALL,
    CMPL_EDGE_ANY
  } cmpl_edge_t;

  typedef struct packed {
    logic       comparator_on;
    logic       comparator_pin_drive;
    logic       output_invert;
    cmpl_edge_t event_edge_select;
    logic       reference_select;
    logic [1:0] negative_input_select;
  } cmpl_cmp_setup_t;

  typedef struct packed {
    logic       ladder_power;
    logic       ladder_pin_output;
    logic       ladder_range;
    logic       ladder_source;
    logic [3:0] ladder_tap;
  } cmpl_ladder_t;

endpackage

// >>> verilog/cmpl_event.sv
/*
  One comparator channel: synchronises the raw analog result, applies
  the inversion and enable, and pulses on the selected output event.
  Assumes CMP_RAW is asynchronous to CLOCK.
*/
`include "cmpl_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module cmpl_event (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     cmp_raw,
  input  wire cmpl_pkg::cmpl_cmp_setup_t setup,
  output logic                          result,
  output logic                          event_pulse
);

  logic sync1_q;
  logic sync2_q;
  logic result_q;
  logic result_d;
  logic on_prev_q;
  logic rise;
  logic fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
    end else begin
      sync1_q <= cmp_raw;
      sync2_q <= sync1_q;
    end
  end

  // Disabled comparator reads low and raises no events
  assign result_d = setup.comparator_on & (sync2_q ^ setup.output_invert);

  always_ff @(posedge clk) begin
    if (rst) begin
      result_q  <= 1'h0;
      on_prev_q <= 1'h0;
    end else begin
      result_q  <= result_d;
      on_prev_q <= setup.comparator_on;
    end
  end

  assign rise = on_prev_q & setup.comparator_on & ~result_q & result_d;
  assign fall = on_prev_q & setup.comparator_on & result_q & ~result_d;

  always_comb begin
    unique case (setup.event_edge_select)
      cmpl_pkg::CMPL_EDGE_NONE: event_pulse = 1'h0;
      cmpl_pkg::CMPL_EDGE_RISE: event_pulse = rise;
      cmpl_pkg::CMPL_EDGE_FALL: event_pulse = fall;
      cmpl_pkg::CMPL_EDGE_ANY:  event_pulse = rise | fall;
    endcase
  end

  assign result = result_q;

endmodule

`default_nettype wire

// >>> verilog/cmpl_top.sv
/*
  Register bank for two comparators and the reference ladder, reached
  over AHB-Lite, with sticky event flags and wake-up from sleep.
  Assumes CPU_SLEEP, PORT_F_DIRECTION5 and the bus are on CLOCK and
  the comparator raw results are asynchronous analog outputs.
*/
// Register access over AHB-Lite and the register offsets were left to the implementer.
`include "cmpl_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module cmpl_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                     CLOCK,
  input  wire logic                     SYS_RST,
  input  wire logic                     HSEL,
  input  wire logic [31:0]              HADDR,
  input  wire logic [1:0]               HTRANS,
  input  wire logic                     HWRITE,
  input  wire logic [2:0]               HSIZE,
  input  wire logic [31:0]              HWDATA,
  input  wire logic                     HREADY,
  output logic      [31:0]              HRDATA,
  output logic                          HREADYOUT,
  output logic                          HRESP,
  input  wire logic [1:0]               CMP_RAW,
  input  wire logic                     CPU_SLEEP,
  input  wire logic                     PORT_F_DIRECTION5,
  output cmpl_pkg::cmpl_cmp_setup_t     CMP1_SETUP,
  output cmpl_pkg::cmpl_cmp_setup_t     CMP2_SETUP,
  output cmpl_pkg::cmpl_ladder_t        LADDER_SETUP,
  output logic      [7:0]               TIMER4_PERIOD,
  output logic      [1:0]               RESULT,
  output logic      [1:0]               EVENT_FLAGS,
  output logic                          LADDER_TO_PIN,
  output logic                          PORT_F5_DIR_EFF,
  output logic                          WAKE
);

  cmpl_pkg::cmpl_cmp_setup_t cmp_q [`CMPL_NUM_CMP];
  cmpl_pkg::cmpl_ladder_t    ladder_q;
  logic [7:0]                period_q;
  logic                      bank_q;
  logic [1:0]                flags_q;
  logic [1:0]                flags_d;
  logic [1:0]                ien_q;
  logic [1:0]                result_w;
  logic [1:0]                event_w;

  logic                      addr_phase;
  logic                      wr_pend_q;
  logic                      rd_pend_q;
  logic [ADDR_W-1:0]         addr_q;
  logic                      wr_en;
  logic [7:0]                wbyte;
  logic [31:0]               rd_mux;
  logic                      ready_q;
  logic [31:0]               rdata_q;
  logic                      wake_q;
  logic                      pin_q;
  logic                      dir_q;

  // Bus address phase: only NONSEQ transfers are claimed, of any HSIZE
  assign addr_phase = HSEL & HREADY & (HTRANS == `CMPL_HTRANS_NONSEQ);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_pend_q <= 1'h0;
      rd_pend_q <= 1'h0;
      addr_q    <= '0;
    end else begin
      if (HREADY) begin
        wr_pend_q <= addr_phase & HWRITE;
        rd_pend_q <= addr_phase & ~HWRITE;
      end else begin
        rd_pend_q <= 1'h0;
      end
      if (addr_phase) begin
        addr_q <= HADDR[ADDR_W-1:0];
      end
    end
  end

  assign wr_en = wr_pend_q;
  assign wbyte = HWDATA[7:0];

  // Reads get one wait state so data always reflects the latest write
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ready_q <= 1'h1;
      rdata_q <= `CMPL_ZERO_WORD;
    end else begin
      ready_q <= ~(addr_phase & ~HWRITE);
      if (rd_pend_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign HREADYOUT = ready_q;
  assign HRDATA    = rdata_q;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      HRESP <= `CMPL_HRESP_OKAY;
    end else begin
      HRESP <= `CMPL_HRESP_OKAY;
    end
  end

  // Read mux: narrow registers in low bits, bank bit at bit 4 of the wdog word, everything else zero
  always_comb begin
    rd_mux = `CMPL_ZERO_WORD;
    unique case (addr_q[7:0])
      `CMPL_OFS_CMP1:   rd_mux[7:0] = cmp_q[0];
      `CMPL_OFS_CMP2:   rd_mux[7:0] = cmp_q[1];
      `CMPL_OFS_RESULT: rd_mux[1:0] = result_w;
      `CMPL_OFS_SHARED: rd_mux[7:0] = bank_q ? ladder_q : period_q;
      `CMPL_OFS_WDOG:   rd_mux[`CMPL_BANK_BIT] = bank_q;
      `CMPL_OFS_FLAGS:  rd_mux[1:0] = flags_q;
      `CMPL_OFS_IEN:    rd_mux[1:0] = ien_q;
      default:          rd_mux = `CMPL_ZERO_WORD;
    endcase
  end

  // Comparator setups: only reset and bus writes change them
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cmp_q[0] <= `CMPL_RST_CMP;
      cmp_q[1] <= `CMPL_RST_CMP;
    end else if (wr_en) begin
      if (addr_q[7:0] == `CMPL_OFS_CMP1) begin
        cmp_q[0] <= wbyte;
      end
      if (addr_q[7:0] == `CMPL_OFS_CMP2) begin
        cmp_q[1] <= wbyte;
      end
    end
  end

  // Shared address: bank bit decides ladder or timer4 period
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ladder_q <= `CMPL_RST_LADDER;
      period_q <= `CMPL_RST_PERIOD;
    end else if (wr_en && addr_q[7:0] == `CMPL_OFS_SHARED) begin
      if (bank_q) begin
        ladder_q <= wbyte;
      end else begin
        period_q <= wbyte;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      bank_q <= 1'h0;
      ien_q  <= 2'h0;
    end else if (wr_en) begin
      if (addr_q[7:0] == `CMPL_OFS_WDOG) begin
        bank_q <= wbyte[`CMPL_BANK_BIT];
      end
      if (addr_q[7:0] == `CMPL_OFS_IEN) begin
        ien_q <= wbyte[1:0];
      end
    end
  end

  // Channels run regardless of sleep
  genvar gi;
  generate
    for (gi = 0; gi < `CMPL_NUM_CMP; gi++) begin : g_ch
      cmpl_event u_event (
        .clk         (CLOCK),
        .rst         (SYS_RST),
        .cmp_raw     (CMP_RAW[gi]),
        .setup       (cmp_q[gi]),
        .result      (result_w[gi]),
        .event_pulse (event_w[gi])
      );
    end
  endgenerate

  // Software may write flags (also to simulate an event); hardware set wins
  always_comb begin
    flags_d = flags_q;
    if (wr_en && addr_q[7:0] == `CMPL_OFS_FLAGS) begin
      flags_d = wbyte[1:0];
    end
    flags_d = flags_d | event_w;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      flags_q <= `CMPL_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Wake request while asleep, and ladder pin direction override
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wake_q <= 1'h0;
      pin_q  <= 1'h0;
      dir_q  <= 1'h1;
    end else begin
      wake_q <= CPU_SLEEP & |(flags_q & ien_q);
      pin_q  <= ladder_q.ladder_pin_output;
      dir_q  <= ladder_q.ladder_pin_output | PORT_F_DIRECTION5;
    end
  end

  assign CMP1_SETUP      = cmp_q[0];
  assign CMP2_SETUP      = cmp_q[1];
  assign LADDER_SETUP    = ladder_q;
  assign TIMER4_PERIOD   = period_q;
  assign RESULT          = result_w;
  assign EVENT_FLAGS     = flags_q;
  assign LADDER_TO_PIN   = pin_q;
  assign PORT_F5_DIR_EFF = dir_q;
  assign WAKE            = wake_q;

  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  a_flag_sets_on_event: assert property (
    event_w[0] |=> flags_q[0]
  ) else $error("event did not set flag one");

  a_flag_stays_set: assert property (
    flags_q[1] && !(wr_en && addr_q[7:0] == `CMPL_OFS_FLAGS) |=> flags_q[1]
  ) else $error("flag two dropped without a clear");

  a_rise_sets_flag: assert property (
    cmp_q[0].comparator_on && cmp_q[0].event_edge_select == cmpl_pkg::CMPL_EDGE_RISE
      && $rose(result_w[0]) && $stable(cmp_q[0]) && $past(cmp_q[0], 2) == cmp_q[0] |-> flags_q[0]
  ) else $error("rising output missed");

  a_none_no_event: assert property (
    cmp_q[1].event_edge_select == cmpl_pkg::CMPL_EDGE_NONE |-> !event_w[1]
  ) else $error("event raised with selection none");

  a_off_reads_low: assert property (
    !cmp_q[0].comparator_on |=> !result_w[0]
  ) else $error("disabled comparator reads high");

  a_wake_on_flag: assert property (
    CPU_SLEEP && (flags_q & ien_q) != 2'h0 |=> WAKE
  ) else $error("enabled flag did not wake");

  a_sleep_keeps_cfg: assert property (
    CPU_SLEEP && !wr_en |=> $stable(cmp_q[0]) && $stable(cmp_q[1])
  ) else $error("setup changed without a write");

  a_sleep_keeps_ladder: assert property (
    !wr_en |=> $stable(ladder_q)
  ) else $error("ladder changed without a write");

  a_bank_guards_ladder: assert property (
    wr_en && addr_q[7:0] == `CMPL_OFS_SHARED && !bank_q |=> $stable(ladder_q)
  ) else $error("ladder written with bank bit clear");

  a_reset_clears_cfg: assert property (
    $past(SYS_RST) |-> cmp_q[0] == `CMPL_RST_CMP && cmp_q[1] == `CMPL_RST_CMP && ladder_q == `CMPL_RST_LADDER
  ) else $error("setup not cleared by reset");

  a_result_upper_zero: assert property (
    rd_pend_q && addr_q[7:0] == `CMPL_OFS_RESULT |=> HRDATA[31:2] == 30'h0 && HREADYOUT
  ) else $error("result register upper bits not zero");

  a_pin_overrides_dir: assert property (
    ladder_q.ladder_pin_output |=> PORT_F5_DIR_EFF && LADDER_TO_PIN
  ) else $error("ladder pin output did not override direction");

  a_write_lands: assert property (
    wr_en && addr_q[7:0] == `CMPL_OFS_CMP2 |=> cmp_q[1] == $past(wbyte)
  ) else $error("comparator two write lost");

endmodule

`default_nettype wire

// >>> tb/cmpl_tb_top.sv
/*
  Self-checking bench for the comparator and ladder register bank.
  Assumes the design top cmpl_top with its AHB-Lite slave port, the
  offsets of cmpl_defines.svh and the types of cmpl_pkg.
*/
`include "cmpl_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module cmpl_tb_top;
  logic                      clock = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = 32'h0000_0000;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [31:0]               hwdata = 32'h0000_0000;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  logic                      hresp;
  logic [1:0]                cmp_raw = 2'h0;
  logic                      cpu_sleep = 1'b0;
  logic                      port_dir5 = 1'b0;
  cmpl_pkg::cmpl_cmp_setup_t cmp1_setup;
  cmpl_pkg::cmpl_cmp_setup_t cmp2_setup;
  cmpl_pkg::cmpl_ladder_t    ladder_setup;
  logic [7:0]                timer4_period;
  logic [1:0]                result;
  logic [1:0]                event_flags;
  logic                      ladder_to_pin;
  logic                      port_dir_eff;
  logic                      wake;
  logic [31:0]               rd;
  int                        miscompares = 0;
  int                        total_checks = 0;

  always #50 clock = ~clock;

  cmpl_top uut (
    .CLOCK(clock), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CMP_RAW(cmp_raw), .CPU_SLEEP(cpu_sleep),
    .PORT_F_DIRECTION5(port_dir5), .CMP1_SETUP(cmp1_setup), .CMP2_SETUP(cmp2_setup),
    .LADDER_SETUP(ladder_setup), .TIMER4_PERIOD(timer4_period), .RESULT(result),
    .EVENT_FLAGS(event_flags), .LADDER_TO_PIN(ladder_to_pin), .PORT_F5_DIR_EFF(port_dir_eff),
    .WAKE(wake)
  );

  task automatic tally_and_finish;
    $display("Checks: %0d, mismatches: %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp || hresp !== 1'b0) begin
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      miscompares++;
    end
  endtask

  // Waits for a rising edge at which hready is high, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        $display("ERROR at %0t: bus hang", $time);
        miscompares++;
        tally_and_finish;
      end
      @(posedge clock);
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= `CMPL_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wait_ready;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    bus_xfer(1'b0, a, 8'h00);
    check(rd, {24'h00_0000, exp}, what);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic do_reset;
    sys_rst <= 1'b1;
    idle(4);
    sys_rst <= 1'b0;
    idle(2);
  endtask

  initial begin
    do_reset;
    rd_chk(`CMPL_OFS_CMP1, 8'h00, "cmp1 reset");
    rd_chk(`CMPL_OFS_CMP2, 8'h00, "cmp2 reset");
    rd_chk(`CMPL_OFS_RESULT, 8'h00, "result reset");
    rd_chk(`CMPL_OFS_SHARED, 8'hff, "period via bank0");
    wr(`CMPL_OFS_SHARED, 8'h3c);
    rd_chk(`CMPL_OFS_SHARED, 8'h3c, "period write");
    rd_chk(8'h1c, 8'h00, "unmapped read");
    wr(`CMPL_OFS_WDOG, 8'h10);
    rd_chk(`CMPL_OFS_SHARED, 8'h00, "ladder reset");
    wr(`CMPL_OFS_SHARED, 8'hd5);
    idle(2);
    check({24'h0, ladder_setup}, 32'h0000_00d5, "ladder port");
    check({24'h0, timer4_period}, 32'h0000_003c, "period kept");
    check({31'h0, ladder_to_pin}, 32'h1, "level to pin");
    check({31'h0, port_dir_eff}, 32'h1, "pin dir override");
    wr(`CMPL_OFS_SHARED, 8'h2a);
    idle(2);
    check({31'h0, ladder_setup.ladder_range}, 32'h1, "range bit");
    check({28'h0, ladder_setup.ladder_tap}, 32'ha, "tap bits");
    check({31'h0, port_dir_eff}, 32'h0, "pin dir released");
    port_dir5 <= 1'b1;
    idle(2);
    check({31'h0, port_dir_eff}, 32'h1, "pin dir from port");
    port_dir5 <= 1'b0;
    // Comparator two enabled, inverted, any edge, low raw input: reads high, no event on enable
    wr(`CMPL_OFS_CMP2, 8'hb8);
    wr(`CMPL_OFS_RESULT, 8'hff);
    idle(5);
    rd_chk(`CMPL_OFS_RESULT, 8'h02, "result inverted");
    check({30'h0, result}, 32'h2, "result port");
    check({30'h0, event_flags}, 32'h0, "no event on enable");
    rd_chk(`CMPL_OFS_RESULT, 8'h02, "result still");
    wr(`CMPL_OFS_FLAGS, 8'h02);
    idle(2);
    rd_chk(`CMPL_OFS_FLAGS, 8'h02, "soft flag two");
    for (int e = 0; e < 4; e++) begin
      wr(`CMPL_OFS_CMP1, 8'h80 | 8'(e << 3));
      wr(`CMPL_OFS_FLAGS, 8'h00);
      cmp_raw[0] <= 1'b1;
      idle(6);
      rd_chk(`CMPL_OFS_FLAGS, {7'h0, 1'(e & 1)}, "rise flag");
      rd_chk(`CMPL_OFS_FLAGS, {7'h0, 1'(e & 1)}, "flag sticks");
      wr(`CMPL_OFS_FLAGS, 8'h00);
      cmp_raw[0] <= 1'b0;
      idle(6);
      rd_chk(`CMPL_OFS_FLAGS, {7'h0, 1'((e >> 1) & 1)}, "fall flag");
    end
    // Sleep: the enabled event must wake the device, settings survive
    wr(`CMPL_OFS_CMP1, 8'h88);
    wr(`CMPL_OFS_IEN, 8'h01);
    wr(`CMPL_OFS_FLAGS, 8'h00);
    cpu_sleep <= 1'b1;
    idle(3);
    check({31'h0, wake}, 32'h0, "no wake yet");
    cmp_raw[0] <= 1'b1;
    for (int n = 0; n < 10 && wake !== 1'b1; n++) begin
      @(posedge clock);
    end
    check({31'h0, wake}, 32'h1, "wake on event");
    if (wake !== 1'b1) begin
      tally_and_finish;
    end
    cpu_sleep <= 1'b0;
    rd_chk(`CMPL_OFS_CMP1, 8'h88, "cmp1 after wake");
    check({31'h0, wake}, 32'h0, "no wake when awake");
    rd_chk(`CMPL_OFS_CMP2, 8'hb8, "cmp2 after wake");
    rd_chk(`CMPL_OFS_SHARED, 8'h2a, "ladder after wake");
    do_reset;
    check({24'h0, cmp1_setup}, 32'h0, "cmp1 off");
    check({24'h0, cmp2_setup}, 32'h0, "cmp2 off");
    check({24'h0, ladder_setup}, 32'h0, "ladder off");
    rd_chk(`CMPL_OFS_RESULT, 8'h00, "result off");
    tally_and_finish;
  end
endmodule

`default_nettype wire
